// >>> rtl/qrw_defines.svh
/*
 * Constants for the quad I/O read path: opcodes, dummy counts,
 * phase lengths, wrap field positions and reset values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef QRW_DEFINES_SVH
`define QRW_DEFINES_SVH

`define QRW_OP_FAST      8'heb
`define QRW_OP_WORD      8'he7
`define QRW_OP_OCTAL     8'he3
`define QRW_DUMMY_FAST   3'h4
`define QRW_DUMMY_WORD   3'h2
`define QRW_DUMMY_OCTAL  3'h0
`define QRW_OPC_LAST     3'h7
`define QRW_ADDR_LAST    3'h5
`define QRW_MODE_LAST    3'h1
`define QRW_SKIP_CODE    2'h2
`define QRW_RESET_CLKS   4'h8
`define QRW_WRAP_RESET   3'h1
`define QRW_WRAP_DIS_POS 0
`define QRW_WRAP_LEN_MSB 2
`define QRW_WRAP_LEN_LSB 1

`endif

// >>> rtl/qrw_pkg.sv
/*
 * Types shared by the quad I/O read path: frame states, command
 * kinds, and the pin bundles in and out.
 * Assumes nothing of its surroundings.
 */
package qrw_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OPC,
        ST_ADDR,
        ST_MODE,
        ST_DUMMY,
        ST_DATA,
        ST_IGNORE
    } qrw_state_t;

    typedef enum logic [1:0] {
        CMD_FAST,
        CMD_WORD,
        CMD_OCTAL
    } qrw_cmd_t;

    typedef struct packed {
        logic       cs_n;
        logic       sclk;
        logic [3:0] quad_line;
    } qrw_pins_t;

    typedef struct packed {
        logic [3:0] oe;
        logic [3:0] dout;
    } qrw_pad_t;

endpackage

// >>> rtl/qrw_quad_read.sv
/*
 * Device-side read path for the quad I/O read commands, with
 * continuous (opcode-less) mode and, for fast and word reads, wrapped bursts in a page.
 * Assumes pins arrive asynchronously and are oversampled by
 * i_core_clk; a memory answers each o_rd_req with one byte.
 */
`timescale 1ns/1ps
`include "qrw_defines.svh"

module qrw_quad_read (
    input  wire logic               i_core_clk,
    input  wire logic               i_rst,
    input  wire qrw_pkg::qrw_pins_t i_pins,
    output qrw_pkg::qrw_pad_t       o_pad,
    input  wire logic               i_quad_enable_bit,
    input  wire logic [2:0]         i_burst_wrap_bits,
    input  wire logic               i_wrap_load,
    output logic                    o_rd_req,
    output logic [23:0]             o_rd_addr,
    input  wire logic [7:0]         i_rd_data,
    input  wire logic               i_rd_valid,
    output logic                    o_rd_ready,
    output logic                    o_continuous_active,
    output logic                    o_wrap_disable_bit
);
    import qrw_pkg::*;

    function automatic logic [2:0] qrw_dummies(input qrw_cmd_t c);
        case (c)
            CMD_FAST: qrw_dummies = `QRW_DUMMY_FAST;
            CMD_WORD: qrw_dummies = `QRW_DUMMY_WORD;
            default:  qrw_dummies = `QRW_DUMMY_OCTAL;
        endcase
    endfunction

    function automatic logic [7:0] qrw_wrap_mask(input logic [1:0] len);
        case (len)
            2'h0:    qrw_wrap_mask = 8'h07;
            2'h1:    qrw_wrap_mask = 8'h0f;
            2'h2:    qrw_wrap_mask = 8'h1f;
            default: qrw_wrap_mask = 8'h3f;
        endcase
    endfunction

    function automatic logic [23:0] qrw_next(input logic [23:0] a, input logic wrap,
                                             input logic [1:0] len);
        logic [7:0] m;
        m = qrw_wrap_mask(len);
        if (wrap)
            qrw_next = {a[23:8], (a[7:0] & ~m) | ((a[7:0] + 8'h01) & m)};
        else
            qrw_next = a + 24'h000001;
    endfunction

    function automatic logic [23:0] qrw_align(input qrw_cmd_t c, input logic [23:0] a);
        case (c)
            CMD_WORD:  qrw_align = {a[23:1], 1'h0};
            CMD_OCTAL: qrw_align = {a[23:4], 4'h0};
            default:   qrw_align = a;
        endcase
    endfunction

    qrw_pins_t   pin_s1;
    qrw_pins_t   pin_s2;
    qrw_pins_t   pin_s3;
    qrw_state_t  state_reg;
    qrw_cmd_t    cmd_reg;
    qrw_cmd_t    cont_cmd_reg;
    logic [2:0]  cnt_reg;
    logic [6:0]  opc_reg;
    logic [19:0] addr_reg;
    logic [3:0]  mode_hi_reg;
    logic        cont_reg;
    logic        ones_reg;
    logic [3:0]  rise_cnt_reg;
    logic [2:0]  wrap_reg;
    logic        fetch_on_reg;
    logic [23:0] fetch_addr_reg;
    logic [23:0] base_addr_reg;
    logic        pending_reg;
    logic        discard_reg;
    logic [7:0]  buf_mem [0:1];
    logic        wr_ptr_reg;
    logic        rd_ptr_reg;
    logic [1:0]  buf_cnt_reg;
    logic [1:0]  buf_cnt_next;
    logic        nib_reg;
    logic [7:0]  out_byte_reg;
    logic [2:0]  dummy_seen_reg;
    logic        rise;
    logic        fall;
    logic        cs_fall;
    logic        cs_rise;
    logic        wrap_on;
    logic        push;
    logic        pop;

    // Two-stage synchroniser, third stage for edge finding
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            pin_s1 <= '{cs_n: 1'h1, sclk: 1'h0, quad_line: 4'h0};
            pin_s2 <= '{cs_n: 1'h1, sclk: 1'h0, quad_line: 4'h0};
            pin_s3 <= '{cs_n: 1'h1, sclk: 1'h0, quad_line: 4'h0};
        end else begin
            pin_s1 <= i_pins;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    assign rise    = pin_s2.sclk & ~pin_s3.sclk & ~pin_s2.cs_n;
    assign fall    = ~pin_s2.sclk & pin_s3.sclk & ~pin_s2.cs_n;
    assign cs_fall = ~pin_s2.cs_n & pin_s3.cs_n;
    assign cs_rise = pin_s2.cs_n & ~pin_s3.cs_n;
    assign wrap_on = ~wrap_reg[`QRW_WRAP_DIS_POS] && (cmd_reg != CMD_OCTAL);

    // Frame sequencer: opcode, address, mode, dummies, data
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_reg   <= ST_IDLE;
            cmd_reg     <= CMD_FAST;
            cnt_reg     <= 3'h0;
            opc_reg     <= 7'h00;
            addr_reg    <= 20'h00000;
            mode_hi_reg <= 4'h0;
        end else if (pin_s2.cs_n) begin
            state_reg <= ST_IDLE;
        end else if (cs_fall) begin
            state_reg <= cont_reg ? ST_ADDR : ST_OPC;
            cmd_reg   <= cont_cmd_reg;
            cnt_reg   <= 3'h0;
        end else if (rise) begin
            case (state_reg)
                ST_OPC: begin
                    opc_reg <= {opc_reg[5:0], pin_s2.quad_line[0]};
                    cnt_reg <= cnt_reg + 3'h1;
                    if (cnt_reg == `QRW_OPC_LAST) begin
                        state_reg <= i_quad_enable_bit ? ST_ADDR : ST_IGNORE;
                        case ({opc_reg, pin_s2.quad_line[0]})
                            `QRW_OP_FAST:  cmd_reg <= CMD_FAST;
                            `QRW_OP_WORD:  cmd_reg <= CMD_WORD;
                            `QRW_OP_OCTAL: cmd_reg <= CMD_OCTAL;
                            default:       state_reg <= ST_IGNORE;
                        endcase
                    end
                end
                ST_ADDR: begin
                    addr_reg <= {addr_reg[15:0], pin_s2.quad_line};
                    cnt_reg  <= cnt_reg + 3'h1;
                    if (cnt_reg == `QRW_ADDR_LAST) begin
                        cnt_reg   <= 3'h0;
                        state_reg <= ST_MODE;
                    end
                end
                ST_MODE: begin
                    cnt_reg <= cnt_reg + 3'h1;
                    if (cnt_reg == 3'h0)
                        mode_hi_reg <= pin_s2.quad_line;
                    if (cnt_reg == `QRW_MODE_LAST) begin
                        cnt_reg   <= 3'h0;
                        state_reg <= (qrw_dummies(cmd_reg) == 3'h0) ? ST_DATA : ST_DUMMY;
                    end
                end
                ST_DUMMY: begin
                    cnt_reg <= cnt_reg + 3'h1;
                    if (cnt_reg == qrw_dummies(cmd_reg) - 3'h1)
                        state_reg <= ST_DATA;
                end
                default: state_reg <= state_reg;
            endcase
        end
    end

    // Continuous mode: lower mode nibble never looked at
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cont_reg     <= 1'h0;
            cont_cmd_reg <= CMD_FAST;
        end else if (rise && state_reg == ST_MODE && cnt_reg == `QRW_MODE_LAST) begin
            cont_reg     <= (mode_hi_reg[1:0] == `QRW_SKIP_CODE);
            cont_cmd_reg <= cmd_reg;
        end else if (cs_rise && cont_reg && ones_reg && rise_cnt_reg == `QRW_RESET_CLKS) begin
            cont_reg <= 1'h0;
        end
    end

    // Watch for the eight-clock all-ones reset frame
    always_ff @(posedge i_core_clk) begin
        if (i_rst || cs_fall) begin
            ones_reg     <= 1'h1;
            rise_cnt_reg <= 4'h0;
        end else if (rise) begin
            ones_reg <= ones_reg & (&pin_s2.quad_line);
            if (rise_cnt_reg != 4'hf)
                rise_cnt_reg <= rise_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            wrap_reg <= `QRW_WRAP_RESET;
        else if (i_wrap_load)
            wrap_reg <= i_burst_wrap_bits;
    end

    // Fetch: one read in flight, never more than buffer room
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            fetch_on_reg   <= 1'h0;
            fetch_addr_reg <= 24'h000000;
            base_addr_reg  <= 24'h000000;
            pending_reg    <= 1'h0;
            discard_reg    <= 1'h0;
            o_rd_req       <= 1'h0;
            o_rd_addr      <= 24'h000000;
        end else begin
            o_rd_req <= 1'h0;
            if (i_rd_valid) begin
                pending_reg <= 1'h0;
                discard_reg <= 1'h0;
            end
            if (cs_rise) begin
                fetch_on_reg <= 1'h0;
                if (pending_reg && !i_rd_valid)
                    discard_reg <= 1'h1;
            end else if (rise && state_reg == ST_ADDR && cnt_reg == `QRW_ADDR_LAST) begin
                fetch_on_reg   <= 1'h1;
                fetch_addr_reg <= qrw_align(cmd_reg, {addr_reg, pin_s2.quad_line});
                base_addr_reg  <= qrw_align(cmd_reg, {addr_reg, pin_s2.quad_line});
            end else if (fetch_on_reg && !pending_reg && !discard_reg && buf_cnt_reg != 2'h2) begin
                o_rd_req       <= 1'h1;
                o_rd_addr      <= fetch_addr_reg;
                pending_reg    <= 1'h1;
                fetch_addr_reg <= qrw_next(fetch_addr_reg, wrap_on,
                                           wrap_reg[`QRW_WRAP_LEN_MSB:`QRW_WRAP_LEN_LSB]);
            end
        end
    end

    // Two-entry byte buffer between memory and serialiser
    assign push = i_rd_valid && o_rd_ready && !discard_reg;
    assign pop  = fall && state_reg == ST_DATA && !nib_reg && buf_cnt_reg != 2'h0;

    always_comb begin
        if (cs_rise)
            buf_cnt_next = 2'h0;
        else
            buf_cnt_next = buf_cnt_reg + {1'h0, push} - {1'h0, pop};
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            wr_ptr_reg  <= 1'h0;
            rd_ptr_reg  <= 1'h0;
            buf_cnt_reg <= 2'h0;
            o_rd_ready  <= 1'h1;
        end else begin
            buf_cnt_reg <= buf_cnt_next;
            o_rd_ready  <= buf_cnt_next != 2'h2;
            if (cs_rise) begin
                wr_ptr_reg <= 1'h0;
                rd_ptr_reg <= 1'h0;
            end else begin
                if (push)
                    wr_ptr_reg <= ~wr_ptr_reg;
                if (pop)
                    rd_ptr_reg <= ~rd_ptr_reg;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (push)
            buf_mem[wr_ptr_reg] <= i_rd_data;
    end

    // Serialiser: high nibble first on falling edges
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_pad        <= '{oe: 4'h0, dout: 4'h0};
            nib_reg      <= 1'h0;
            out_byte_reg <= 8'h00;
        end else if (state_reg != ST_DATA) begin
            o_pad.oe <= 4'h0;
            nib_reg  <= 1'h0;
        end else if (fall) begin
            o_pad.oe <= 4'hf;
            nib_reg  <= ~nib_reg;
            if (!nib_reg) begin
                out_byte_reg <= buf_mem[rd_ptr_reg];
                o_pad.dout   <= buf_mem[rd_ptr_reg][7:4];
            end else begin
                o_pad.dout <= out_byte_reg[3:0];
            end
        end
    end

    assign o_continuous_active = cont_reg;
    assign o_wrap_disable_bit  = wrap_reg[`QRW_WRAP_DIS_POS];

    always_ff @(posedge i_core_clk) begin
        if (i_rst || cs_fall)
            dummy_seen_reg <= 3'h0;
        else if (rise && state_reg == ST_DUMMY)
            dummy_seen_reg <= dummy_seen_reg + 3'h1;
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    sequence s_mode_end;
        rise && state_reg == ST_MODE && cnt_reg == 3'h1;
    endsequence

    a_fast_dummy_count: assert property (
        $rose(state_reg == ST_DATA) && cmd_reg == CMD_FAST |-> dummy_seen_reg == 3'h4)
        else $error("fast read data after wrong dummy count");
    a_word_dummy_count: assert property (
        $rose(state_reg == ST_DATA) && cmd_reg == CMD_WORD |-> dummy_seen_reg == 3'h2)
        else $error("word read data after wrong dummy count");
    a_octal_no_dummy: assert property (
        s_mode_end ##0 cmd_reg == CMD_OCTAL |=> state_reg == ST_DATA)
        else $error("octal read did not go straight to data");
    a_qe_gate_off: assert property (
        rise && state_reg == ST_OPC && cnt_reg == 3'h7 && !i_quad_enable_bit
        |=> state_reg == ST_IGNORE)
        else $error("quad read accepted without quad enable");
    a_skip_field_keep: assert property (
        s_mode_end ##0 mode_hi_reg[1:0] == 2'h2 |=> cont_reg [*2])
        else $error("continuous mode not entered");
    a_skip_field_drop: assert property (
        s_mode_end ##0 mode_hi_reg[1:0] != 2'h2 |=> !cont_reg)
        else $error("continuous mode kept on wrong skip field");
    a_cont_no_opcode: assert property (
        cs_fall && cont_reg |=> state_reg == ST_ADDR && cmd_reg == $past(cont_cmd_reg))
        else $error("continuous frame did not start at address");
    a_ones_reset_exit: assert property (
        cs_rise && ones_reg && rise_cnt_reg == 4'h8 |=> !cont_reg [*2])
        else $error("all-ones frame did not leave continuous mode");
    a_wrap_in_section: assert property (
        o_rd_req && wrap_on |-> o_rd_addr[23:8] == base_addr_reg[23:8] &&
        ((o_rd_addr[7:0] ^ base_addr_reg[7:0]) & ~qrw_wrap_mask(wrap_reg[2:1])) == 8'h00)
        else $error("wrapped fetch left its section");
    a_drive_in_data: assert property (
        o_pad.oe != 4'h0 |-> $past(state_reg) == ST_DATA)
        else $error("lines driven outside data phase");
    a_wrap_power_up: assert property (
        @(posedge i_core_clk) disable iff (1'b0) $past(i_rst) |-> wrap_reg[0])
        else $error("wrap not disabled after reset");

endmodule

// >>> tb/qrw_host_model.sv
/*
 * Host controller model for the quad I/O read path: drives chip
 * select, serial clock and the four IO lines, and collects data.
 * Assumes the testbench calls its tasks and feeds back the pads.
 */
`timescale 1ns/1ps

module qrw_host_model (
    input  wire logic              i_core_clk,
    input  wire qrw_pkg::qrw_pad_t i_pad,
    output qrw_pkg::qrw_pins_t     o_pins
);
    import qrw_pkg::*;

    localparam int HALF = 8;

    logic       cs_n_reg  = 1'b1;
    logic       sclk_reg  = 1'b0;
    logic       drive_reg = 1'b0;
    logic [3:0] val_reg   = 4'h0;
    logic [3:0] float_reg = 4'h5;
    logic       saw_oe    = 1'b0;
    logic [7:0] rx_bytes [0:7];

    // Undriven lines toggle so a stale level never passes for data
    always @(posedge i_core_clk) begin
        float_reg <= ~float_reg;
        if (|i_pad.oe) begin
            saw_oe = 1'b1;
        end
    end

    assign o_pins.cs_n      = cs_n_reg;
    assign o_pins.sclk      = sclk_reg;
    assign o_pins.quad_line = (i_pad.oe & i_pad.dout) |
                              (~i_pad.oe & (drive_reg ? val_reg : float_reg));

    task automatic half_wait();
        repeat (HALF) @(posedge i_core_clk);
        #1;
    endtask

    task automatic pulse(input logic [3:0] nib, input logic drv, input logic rel,
                         output logic [3:0] got);
        drive_reg = drv;
        val_reg = nib;
        half_wait();
        sclk_reg = 1'b1;
        got = o_pins.quad_line;
        repeat (HALF - 2) @(posedge i_core_clk);
        #1;
        if (rel) begin
            drive_reg = 1'b0;
        end
        repeat (2) @(posedge i_core_clk);
        #1;
        sclk_reg = 1'b0;
    endtask

    task automatic end_frame();
        half_wait();
        drive_reg = 1'b0;
        cs_n_reg = 1'b1;
        repeat (8) @(posedge i_core_clk);
        #1;
    endtask

    task automatic frame(input logic opc_on, input logic [7:0] opc, input logic [23:0] addr,
                         input logic [7:0] mode, input int dum, input int n);
        logic [3:0] got;
        logic [3:0] hi;
        saw_oe = 1'b0;
        cs_n_reg = 1'b0;
        if (opc_on) begin
            for (int i = 7; i >= 0; i--) pulse({3'h0, opc[i]}, 1'b1, 1'b0, got);
        end
        for (int i = 5; i >= 0; i--) pulse(addr[i*4 +: 4], 1'b1, 1'b0, got);
        pulse(mode[7:4], 1'b1, 1'b0, got);
        pulse(mode[3:0], 1'b1, dum == 0, got);
        for (int i = 0; i < dum; i++) pulse(4'hf, 1'b1, i == dum - 1, got);
        for (int i = 0; i < n; i++) begin
            pulse(4'h0, 1'b0, 1'b0, hi);
            pulse(4'h0, 1'b0, 1'b0, got);
            rx_bytes[i] = {hi, got};
        end
        end_frame();
    endtask

    task automatic reset_frame();
        logic [3:0] got;
        cs_n_reg = 1'b0;
        for (int i = 0; i < 8; i++) pulse(4'hf, 1'b1, 1'b0, got);
        end_frame();
    endtask
endmodule

// >>> tb/quad_io_read_continuous_wrap_test.sv
/*
 * Self-checking bench for the quad I/O read path: plain and continuous
 * reads of all three commands and wrapped fast and word reads, with a byte memory model.
 * Assumes the host model sits on the pins and drives the link.
 */
`timescale 1ns/1ps
`include "qrw_defines.svh"

`define QRW_CHK(got, exp) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
end

module quad_io_read_continuous_wrap_test;
    import qrw_pkg::*;

    logic       i_core_clk;
    logic       i_rst;
    qrw_pins_t  pins;
    qrw_pad_t   pad;
    logic       qe;
    logic [2:0] wrap_bits;
    logic       wrap_load;
    logic       rd_req;
    logic [23:0] rd_addr;
    logic [7:0] rd_data;
    logic       rd_valid;
    logic       rd_ready;
    logic       cont;
    logic       wrap_dis;
    logic       fire;
    int         fail_count = 0;
    int         tests_run  = 0;
    int         cycles     = 0;
    int         mem_lat    = 2;
    int         lat_cnt    = 0;

    qrw_quad_read qrw_quad_read_i (
        .i_core_clk          (i_core_clk),
        .i_rst               (i_rst),
        .i_pins              (pins),
        .o_pad               (pad),
        .i_quad_enable_bit   (qe),
        .i_burst_wrap_bits   (wrap_bits),
        .i_wrap_load         (wrap_load),
        .o_rd_req            (rd_req),
        .o_rd_addr           (rd_addr),
        .i_rd_data           (rd_data),
        .i_rd_valid          (rd_valid),
        .o_rd_ready          (rd_ready),
        .o_continuous_active (cont),
        .o_wrap_disable_bit  (wrap_dis)
    );

    qrw_host_model qrw_host_model_i (
        .i_core_clk (i_core_clk),
        .i_pad      (pad),
        .o_pins     (pins)
    );

    initial begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end

    function automatic logic [7:0] pat(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ 8'ha5;
    endfunction

    function automatic logic [23:0] exp_addr(input logic [23:0] start, input int idx,
                                            input logic wrap_on, input int size);
        logic [23:0] mask;
        mask = 24'(size - 1);
        if (!wrap_on) begin
            return start + 24'(idx);
        end
        return (start & ~mask) | ((start + 24'(idx)) & mask);
    endfunction

    // Memory answers each request after mem_lat cycles
    always @(posedge i_core_clk) begin
        fire = 1'b0;
        if (rd_req === 1'b1) begin
            lat_cnt = mem_lat;
        end else if (lat_cnt > 0) begin
            lat_cnt = lat_cnt - 1;
            fire = (lat_cnt == 0);
        end
        rd_valid <= #1 fire;
        if (fire) begin
            rd_data <= #1 pat(rd_addr);
        end
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            $display("wrong value at %0t: run timed out", $time);
            test_done();
        end
    end

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic rd(input logic opc_on, input logic [7:0] opc, input logic [23:0] addr,
                      input logic [7:0] mode, input int dum, input int n,
                      input logic [23:0] start, input logic wrap_on, input int size);
        qrw_host_model_i.frame(opc_on, opc, addr, mode, dum, n);
        for (int i = 0; i < n; i++) begin
            `QRW_CHK(qrw_host_model_i.rx_bytes[i], pat(exp_addr(start, i, wrap_on, size)))
        end
    endtask

    task automatic load_wrap(input logic [2:0] bits);
        @(posedge i_core_clk);
        #1;
        wrap_bits = bits;
        wrap_load = 1'b1;
        @(posedge i_core_clk);
        #1;
        wrap_load = 1'b0;
        @(posedge i_core_clk);
        #1;
    endtask

    initial begin
        i_rst = 1'b1;
        qe = 1'b1;
        wrap_bits = 3'h1;
        wrap_load = 1'b0;
        rd_data = 8'h00;
        rd_valid = 1'b0;
        repeat (8) @(posedge i_core_clk);
        #1;
        i_rst = 1'b0;
        repeat (4) @(posedge i_core_clk);
        #1;
        `QRW_CHK(cont, 1'b0)
        `QRW_CHK(wrap_dis, 1'b1)
        `QRW_CHK(pad.oe, 4'h0)
        `QRW_CHK(rd_ready, 1'b1)
        `QRW_CHK(rd_req, 1'b0)
        $display("test reset done");
        rd(1'b1, `QRW_OP_FAST, 24'h123456, 8'h00, 4, 4, 24'h123456, 1'b0, 8);
        `QRW_CHK(cont, 1'b0)
        `QRW_CHK(rd_ready, 1'b1)
        $display("test fast read done");
        rd(1'b1, `QRW_OP_FAST, 24'h0000a0, 8'h2f, 4, 2, 24'h0000a0, 1'b0, 8);
        `QRW_CHK(cont, 1'b1)
        rd(1'b0, 8'h00, 24'h0000b4, 8'ha0, 4, 2, 24'h0000b4, 1'b0, 8);
        `QRW_CHK(cont, 1'b1)
        rd(1'b0, 8'h00, 24'h0000b8, 8'h30, 4, 2, 24'h0000b8, 1'b0, 8);
        `QRW_CHK(cont, 1'b0)
        rd(1'b1, `QRW_OP_FAST, 24'h0000c0, 8'h20, 4, 2, 24'h0000c0, 1'b0, 8);
        qrw_host_model_i.reset_frame();
        `QRW_CHK(cont, 1'b0)
        rd(1'b1, `QRW_OP_FAST, 24'h0000c8, 8'h00, 4, 2, 24'h0000c8, 1'b0, 8);
        $display("test continuous done");
        qe = 1'b0;
        qrw_host_model_i.frame(1'b1, `QRW_OP_WORD, 24'h000010, 8'h20, 2, 1);
        `QRW_CHK(qrw_host_model_i.saw_oe, 1'b0)
        `QRW_CHK(cont, 1'b0)
        qe = 1'b1;
        $display("test quad enable done");
        mem_lat = 9;
        rd(1'b1, `QRW_OP_WORD, 24'h000203, 8'h20, 2, 4, 24'h000202, 1'b0, 8);
        `QRW_CHK(cont, 1'b1)
        rd(1'b0, 8'h00, 24'h000301, 8'h00, 2, 2, 24'h000300, 1'b0, 8);
        `QRW_CHK(cont, 1'b0)
        mem_lat = 2;
        rd(1'b1, `QRW_OP_OCTAL, 24'h00031f, 8'h20, 0, 4, 24'h000310, 1'b0, 8);
        rd(1'b0, 8'h00, 24'h00042a, 8'h00, 0, 2, 24'h000420, 1'b0, 8);
        $display("test word and octal done");
        for (int c = 0; c < 4; c++) begin
            load_wrap({2'(c), 1'b0});
            `QRW_CHK(wrap_dis, 1'b0)
            rd(1'b1, `QRW_OP_FAST, 24'h000540 + 24'((8 << c) - 2), 8'h00, 4, 4,
               24'h000540 + 24'((8 << c) - 2), 1'b1, 8 << c);
        end
        load_wrap(3'h2);
        rd(1'b1, `QRW_OP_WORD, 24'h00066e, 8'h00, 2, 4, 24'h00066e, 1'b1, 16);
        load_wrap(3'h1);
        `QRW_CHK(wrap_dis, 1'b1)
        rd(1'b1, `QRW_OP_FAST, 24'h00070e, 8'h00, 4, 4, 24'h00070e, 1'b0, 8);
        $display("test wrap done");
        test_done();
    end
endmodule
